// ### include/bus_cycle_pkg.sv
package bus_cycle_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus states
  typedef enum logic [2:0] {
    IDLE,
    ADDRESS,
    DATA,
    DATA_NEXT_ADDRESS_REQUESTED,
    PIPELINE_ADDRESS,
    PIPELINE_DATA,
    TRANSITION
  } bus_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and counts
  localparam int unsigned BURST_BYTES      = 32;
  localparam int unsigned BEAT_BYTES       = 8;
  localparam int unsigned BEATS_PER_BURST  = BURST_BYTES / BEAT_BYTES;
  localparam int unsigned BEAT_COUNT_WIDTH = $clog2(BEATS_PER_BURST);
  localparam int unsigned FREQ_SELECT_WIDTH = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam bus_state_type RESET_STATE = IDLE;
  localparam logic [FREQ_SELECT_WIDTH-1:0] RESET_FREQ_SELECT = 3'h0;
  localparam logic [BEAT_COUNT_WIDTH-1:0] RESET_BEAT_COUNT = 2'h0;

endpackage

// ### hw/burst_beat_counter.sv
`timescale 1ns/1ps
`default_nettype none

module burst_beat_counter #(
  parameter int unsigned BEATS = bus_cycle_pkg::BEATS_PER_BURST
) (
  input  wire logic                                      i_clock,
  input  wire logic                                      i_nrst,
  input  wire logic                                      i_ready,
  input  wire logic                                      i_burst,
  input  wire logic                                      i_abort,
  output logic                                           o_last,
  output logic [bus_cycle_pkg::BEAT_COUNT_WIDTH-1:0]     o_count
);

  typedef struct packed {
    logic [bus_cycle_pkg::BEAT_COUNT_WIDTH-1:0] count;
  } beat_type;

  beat_type q;
  beat_type d;

  localparam logic [bus_cycle_pkg::BEAT_COUNT_WIDTH-1:0] LAST_INDEX =
    bus_cycle_pkg::BEAT_COUNT_WIDTH'(BEATS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Single transfers end on the first ready, bursts on the fourth
  always_comb begin
    d = q;
    o_last = i_ready && (!i_burst || (q.count == LAST_INDEX));
    if (i_abort || o_last) begin
      d.count = bus_cycle_pkg::RESET_BEAT_COUNT;
    end else if (i_ready) begin
      d.count = q.count + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      q.count <= bus_cycle_pkg::RESET_BEAT_COUNT;
    end else begin
      q <= d;
    end
  end

  assign o_count = q.count;

endmodule

`default_nettype wire

// ### hw/bus_cycle_fsm.sv
// Overview of operation
// - All bus inputs sampled and outputs changed on rising bus clock edges.
// - Frequency select caught at reset release; flush caught then and every edge.
// - In boundary-scan mode the bus machine parks in Idle and ignores ready.
// - Idle drives nothing and waits for an internal cycle request.
// - Last ready in Data, or Data-next-address with nothing pending, enters Idle.
// - Reset or backoff sampled asserted forces Idle from any state.
// - Address asserts strobe exactly one clock, then goes to Data.
// - Data moves write data or awaits read; last ready returns Idle.
// - Next-address request before last ready in Data enters Data-next-address.
// - Last ready in Data-next-address goes Address if pending, else Idle.
// - Pipeline Address strobes next cycle; without last ready go Pipeline Data.
// - Last ready in pipeline states inserts Transition on direction change.
// - Next-address request ignored in Pipeline Address; never straight to Data-next.
// - Pipeline Data issues no cycles and serves current data until last ready.
// - Pipeline Data last ready, same direction: Data, or Data-next if requested.
// - Transition lasts one clock, then Data without next-address request.
// - Ready sampled every edge from the one after strobe negation, except in Transition.
// - Burst of 32 bytes completes after four ready beats of 8 bytes; single after one.
// - Without next-address request, one idle clock between last ready and next strobe.
`timescale 1ns/1ps
`default_nettype none

module bus_cycle_fsm (
  input  wire logic                                        i_clock,
  input  wire logic                                        i_nrst,
  input  wire logic                                        i_cycle_request,
  input  wire logic                                        i_cycle_write,
  input  wire logic                                        i_cycle_burst,
  input  wire logic                                        i_burst_ready_n,
  input  wire logic                                        i_next_address_request_n,
  input  wire logic                                        i_backoff_n,
  input  wire logic                                        i_scan_mode,
  input  wire logic [bus_cycle_pkg::FREQ_SELECT_WIDTH-1:0] i_bus_frequency_select,
  input  wire logic                                        i_flush_n,
  output logic                                             o_cycle_accept,
  output logic                                             o_address_strobe_n,
  output logic                                             o_bus_drive_en,
  output logic                                             o_data_drive_en,
  output logic                                             o_beat_valid,
  output logic                                             o_cycle_done,
  output logic [bus_cycle_pkg::FREQ_SELECT_WIDTH-1:0]      o_bus_frequency_select,
  output logic                                             o_flush_at_reset,
  output logic                                             o_flush_request,
  output bus_cycle_pkg::bus_state_type                     o_state
);

  typedef struct packed {
    bus_cycle_pkg::bus_state_type                  state;
    logic                                          cur_write;
    logic                                          cur_burst;
    logic                                          pend_write;
    logic                                          pend_burst;
    logic                                          na_seen;
    logic                                          straps_taken;
    logic [bus_cycle_pkg::FREQ_SELECT_WIDTH-1:0]   freq;
    logic                                          flush_at_reset;
    logic                                          flush_now;
  } ctrl_type;

  ctrl_type q;
  ctrl_type d;

  logic                                          sampling;
  logic                                          ready;
  logic                                          last;
  logic                                          na;
  logic                                          backoff_n;
  logic                                          dir_change;
  logic [bus_cycle_pkg::BEAT_COUNT_WIDTH-1:0]    beat_count;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_strobe(input bus_cycle_pkg::bus_state_type s);
    is_strobe = (s == bus_cycle_pkg::ADDRESS) || (s == bus_cycle_pkg::PIPELINE_ADDRESS);
  endfunction

  function automatic logic is_sampling(input bus_cycle_pkg::bus_state_type s);
    is_sampling = (s == bus_cycle_pkg::DATA) ||
                  (s == bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED) ||
                  (s == bus_cycle_pkg::PIPELINE_ADDRESS) ||
                  (s == bus_cycle_pkg::PIPELINE_DATA);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Ready is only looked at once the current cycle's strobe has dropped
  assign sampling   = is_sampling(q.state) && !i_scan_mode;
  assign ready      = sampling && !i_burst_ready_n;
  assign na         = !i_next_address_request_n;
  assign backoff_n       = !i_backoff_n;
  assign dir_change = q.cur_write != q.pend_write;

  burst_beat_counter #(
    .BEATS (bus_cycle_pkg::BEATS_PER_BURST)
  ) u_beats (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_ready (ready),
    .i_burst (q.cur_burst),
    .i_abort (backoff_n || i_scan_mode),
    .o_last  (last),
    .o_count (beat_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    o_cycle_accept = 1'b0;
    d.flush_now = !i_flush_n;
    if (!q.straps_taken) begin
      d.straps_taken = 1'b1;
      d.freq = i_bus_frequency_select;
      d.flush_at_reset = !i_flush_n;
    end
    case (q.state)
      bus_cycle_pkg::IDLE: begin
        // Without next-address request, a cycle needs an idle clock after completion, given by this state
        if (i_cycle_request) begin
          d.state = bus_cycle_pkg::ADDRESS;
          d.cur_write = i_cycle_write;
          d.cur_burst = i_cycle_burst;
          o_cycle_accept = 1'b1;
        end
      end
      bus_cycle_pkg::ADDRESS: begin
        d.state = bus_cycle_pkg::DATA;
      end
      bus_cycle_pkg::DATA: begin
        if (last) begin
          d.state = bus_cycle_pkg::IDLE;
        end else if (na) begin
          d.state = bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED;
        end
      end
      bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED: begin
        if (last && i_cycle_request) begin
          d.state = bus_cycle_pkg::ADDRESS;
          d.cur_write = i_cycle_write;
          d.cur_burst = i_cycle_burst;
          o_cycle_accept = 1'b1;
        end else if (last) begin
          d.state = bus_cycle_pkg::IDLE;
        end else if (i_cycle_request) begin
          d.state = bus_cycle_pkg::PIPELINE_ADDRESS;
          d.pend_write = i_cycle_write;
          d.pend_burst = i_cycle_burst;
          o_cycle_accept = 1'b1;
        end
      end
      bus_cycle_pkg::PIPELINE_ADDRESS: begin
        // Next-address request is not looked at here at all
        d.na_seen = 1'b0;
        if (last) begin
          d.state = dir_change ? bus_cycle_pkg::TRANSITION : bus_cycle_pkg::DATA;
          d.cur_write = q.pend_write;
          d.cur_burst = q.pend_burst;
        end else begin
          d.state = bus_cycle_pkg::PIPELINE_DATA;
        end
      end
      bus_cycle_pkg::PIPELINE_DATA: begin
        // Two cycles open: requests wait, the current one runs on
        d.na_seen = q.na_seen || na;
        if (last) begin
          d.cur_write = q.pend_write;
          d.cur_burst = q.pend_burst;
          d.na_seen = 1'b0;
          if (dir_change) begin
            d.state = bus_cycle_pkg::TRANSITION;
          end else if (q.na_seen || na) begin
            d.state = bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED;
          end else begin
            d.state = bus_cycle_pkg::DATA;
          end
        end
      end
      bus_cycle_pkg::TRANSITION: begin
        // One dead clock so the two drivers never overlap on the data bus
        d.state = na ? bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED
                     : bus_cycle_pkg::DATA;
      end
      default: begin
        d.state = bus_cycle_pkg::IDLE;
      end
    endcase
    if (backoff_n || i_scan_mode) begin
      d.state = bus_cycle_pkg::IDLE;
      d.na_seen = 1'b0;
      o_cycle_accept = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      q.state <= bus_cycle_pkg::RESET_STATE;
      q.cur_write <= 1'b0;
      q.cur_burst <= 1'b0;
      q.pend_write <= 1'b0;
      q.pend_burst <= 1'b0;
      q.na_seen <= 1'b0;
      q.straps_taken <= 1'b0;
      q.freq <= bus_cycle_pkg::RESET_FREQ_SELECT;
      q.flush_at_reset <= 1'b0;
      q.flush_now <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; address is only meaningful to the far side with the strobe
  assign o_address_strobe_n = !is_strobe(q.state);
  assign o_bus_drive_en = (q.state != bus_cycle_pkg::IDLE) &&
                          (q.state != bus_cycle_pkg::TRANSITION);
  assign o_data_drive_en = sampling && q.cur_write;
  assign o_beat_valid = ready && !backoff_n;
  assign o_cycle_done = last && !backoff_n;
  assign o_bus_frequency_select = q.freq;
  assign o_flush_at_reset = q.flush_at_reset;
  assign o_flush_request = q.flush_now;
  assign o_state = q.state;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_addr_one_clock;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::ADDRESS) && !backoff_n && !i_scan_mode
      |=> (q.state == bus_cycle_pkg::DATA) && o_address_strobe_n;
  endproperty
  a_addr_one_clock: assert property (p_addr_one_clock)
    else $error("address strobe not exactly one clock");

  property p_idle_quiet;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::IDLE) |-> !o_bus_drive_en && o_address_strobe_n
      && !o_data_drive_en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("bus driven in idle");

  property p_backoff_idle;
    @(posedge i_clock) disable iff (!i_nrst)
    backoff_n |=> (q.state == bus_cycle_pkg::IDLE) && o_address_strobe_n;
  endproperty
  a_backoff_idle: assert property (p_backoff_idle)
    else $error("backoff did not force idle");

  property p_data_last_idle;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::DATA) && last && !backoff_n && !i_scan_mode
      |=> (q.state == bus_cycle_pkg::IDLE) && o_address_strobe_n && !o_bus_drive_en;
  endproperty
  a_data_last_idle: assert property (p_data_last_idle)
    else $error("data state did not end in idle with a gap");

  property p_data_na;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::DATA) && !last && na && !backoff_n && !i_scan_mode
      |=> q.state == bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED;
  endproperty
  a_data_na: assert property (p_data_na)
    else $error("early next address request not taken");

  property p_dna_exit;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED) && last && !backoff_n && !i_scan_mode
      |=> q.state == ($past(i_cycle_request) ? bus_cycle_pkg::ADDRESS
                                             : bus_cycle_pkg::IDLE);
  endproperty
  a_dna_exit: assert property (p_dna_exit)
    else $error("wrong exit on last ready after next address request");

  property p_dna_pipe;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED) && !last && i_cycle_request
      && !backoff_n && !i_scan_mode
      |=> !o_address_strobe_n && (q.state == bus_cycle_pkg::PIPELINE_ADDRESS);
  endproperty
  a_dna_pipe: assert property (p_dna_pipe)
    else $error("pipelined strobe not issued");

  property p_pa_next;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::PIPELINE_ADDRESS) && !last && !backoff_n && !i_scan_mode
      |=> (q.state == bus_cycle_pkg::PIPELINE_DATA) && o_address_strobe_n;
  endproperty
  a_pa_next: assert property (p_pa_next)
    else $error("pipeline address did not move to pipeline data");

  property p_turnaround;
    @(posedge i_clock) disable iff (!i_nrst)
    ((q.state == bus_cycle_pkg::PIPELINE_ADDRESS) || (q.state == bus_cycle_pkg::PIPELINE_DATA))
      && last && dir_change && !backoff_n && !i_scan_mode
      |=> (q.state == bus_cycle_pkg::TRANSITION) && !o_data_drive_en
      ##1 (q.state != bus_cycle_pkg::TRANSITION);
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("turnaround clock missing or too long");

  property p_pa_never_dna;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::PIPELINE_ADDRESS)
      |=> q.state != bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED;
  endproperty
  a_pa_never_dna: assert property (p_pa_never_dna)
    else $error("pipeline address jumped to next address requested");

  property p_pd_no_strobe;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::PIPELINE_DATA) |-> o_address_strobe_n && !o_cycle_accept;
  endproperty
  a_pd_no_strobe: assert property (p_pd_no_strobe)
    else $error("new cycle issued with two outstanding");

  property p_pd_same_dir;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::PIPELINE_DATA) && last && !dir_change && !backoff_n && !i_scan_mode
      |=> q.state == ($past(q.na_seen || na) ? bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED
                                            : bus_cycle_pkg::DATA);
  endproperty
  a_pd_same_dir: assert property (p_pd_same_dir)
    else $error("pipeline data exit wrong");

  property p_trans_exit;
    @(posedge i_clock) disable iff (!i_nrst)
    (q.state == bus_cycle_pkg::TRANSITION) && !backoff_n && !i_scan_mode
      |=> q.state == ($past(na) ? bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED
                                : bus_cycle_pkg::DATA);
  endproperty
  a_trans_exit: assert property (p_trans_exit)
    else $error("transition exit wrong");

  property p_no_early_ready;
    @(posedge i_clock) disable iff (!i_nrst)
    o_beat_valid |-> o_bus_drive_en && (q.state != bus_cycle_pkg::ADDRESS);
  endproperty
  a_no_early_ready: assert property (p_no_early_ready)
    else $error("ready taken in the strobe clock");

  property p_burst_beats;
    @(posedge i_clock) disable iff (!i_nrst)
    o_cycle_done && q.cur_burst |-> beat_count == bus_cycle_pkg::BEAT_COUNT_WIDTH'(3);
  endproperty
  a_burst_beats: assert property (p_burst_beats)
    else $error("burst ended before four beats");

  c_pipeline: cover property (@(posedge i_clock) disable iff (!i_nrst)
    q.state == bus_cycle_pkg::PIPELINE_DATA);
  c_transition: cover property (@(posedge i_clock) disable iff (!i_nrst)
    q.state == bus_cycle_pkg::TRANSITION);
  c_burst_done: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_cycle_done && q.cur_burst);
  c_backoff: cover property (@(posedge i_clock) disable iff (!i_nrst)
    backoff_n && (q.state == bus_cycle_pkg::PIPELINE_DATA));

endmodule

`default_nettype wire

// ### bench/system_logic_model.sv
`timescale 1ns/1ps
`default_nettype none

module system_logic_model (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_address_strobe_n,
  input  wire logic       i_burst,
  input  wire logic       i_backoff_n,
  input  wire logic [3:0] i_wait,
  input  wire logic       i_na_en,
  output logic            o_burst_ready_n,
  output logic            o_next_address_request_n
);
  logic [2:0] left_q;
  logic       next_q;
  logic       next_burst_q;
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ready and next-address lines idle high, as with a pull-up
  always @(posedge i_clock or negedge i_nrst) begin : seq
    logic [2:0] cur;
    logic [3:0] w;
    if (!i_nrst) begin
      left_q <= 3'h0;
      next_q <= 1'b0;
      next_burst_q <= 1'b0;
      wait_q <= 4'h0;
      o_burst_ready_n <= 1'b1;
      o_next_address_request_n <= 1'b1;
    end else begin
      cur = left_q - {2'h0, !o_burst_ready_n};
      w = wait_q;
      if (!i_backoff_n) begin
        cur = 3'h0;
        next_q <= 1'b0;
      end else if (!i_address_strobe_n && cur == 3'h0) begin
        cur = i_burst ? 3'h4 : 3'h1;
        w = 4'h0;
      end else if (!i_address_strobe_n) begin
        next_q <= 1'b1;
        next_burst_q <= i_burst;
      end else if (cur == 3'h0 && next_q) begin
        cur = next_burst_q ? 3'h4 : 3'h1;
        w = 4'h0;
        next_q <= 1'b0;
      end
      left_q <= cur;
      // Ready at the earliest on the edge after the strobe is negated
      o_burst_ready_n <= !(cur != 3'h0 && w >= i_wait);
      wait_q <= (cur != 3'h0 && w < i_wait) ? w + 4'h1 : 4'h0;
      o_next_address_request_n <= !(i_na_en && cur != 3'h0);
    end
  end
endmodule

`default_nettype wire

// ### bench/processor_bus_cycle_fsm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module processor_bus_cycle_fsm_tb_top;
  logic       i_clock = 1'b0;
  logic       i_nrst = 1'b0;
  logic       req = 1'b0;
  logic       wr = 1'b0;
  logic       bu = 1'b0;
  logic       backoff_n_n = 1'b1;
  logic       scan = 1'b0;
  logic [2:0] strap = 3'h5;
  logic       flush_n = 1'b0;
  logic       na_en = 1'b0;
  logic [3:0] wt = 4'h0;
  logic       ready_n, na_n, accept, strobe_n, bus_en, data_en, beat, done;
  logic       flush_rst, flush_req, prev_trans, prev_pipe, prev_pd;
  logic [2:0] freq;
  int         err_count = 0;
  int         total_checks = 0;
  int         beats, dones, strobes, trans, pipes, drv, gap, since;
  bus_cycle_pkg::bus_state_type state, after_trans, after_pipe, after_pd;

  always #25 i_clock = ~i_clock;

  bus_cycle_fsm i_bus_cycle_fsm (.i_clock(i_clock), .i_nrst(i_nrst), .i_cycle_request(req),
    .i_cycle_write(wr), .i_cycle_burst(bu), .i_burst_ready_n(ready_n),
    .i_next_address_request_n(na_n), .i_backoff_n(backoff_n_n), .i_scan_mode(scan),
    .i_bus_frequency_select(strap), .i_flush_n(flush_n), .o_cycle_accept(accept),
    .o_address_strobe_n(strobe_n), .o_bus_drive_en(bus_en), .o_data_drive_en(data_en),
    .o_beat_valid(beat), .o_cycle_done(done), .o_bus_frequency_select(freq),
    .o_flush_at_reset(flush_rst), .o_flush_request(flush_req), .o_state(state));

  system_logic_model i_system_logic_model (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_address_strobe_n(strobe_n), .i_burst(bu), .i_backoff_n(backoff_n_n), .i_wait(wt),
    .i_na_en(na_en), .o_burst_ready_n(ready_n), .o_next_address_request_n(na_n));

  ////////////////////////////////////////////////////////////////////////////
  // Bus monitor; gap counts edges from last ready to the next plain strobe
  always @(posedge i_clock) begin
    if (beat === 1'b1) beats++;
    if (beat === 1'b1 && data_en === 1'b1) drv++;
    if (done === 1'b1) dones++;
    if (strobe_n === 1'b0) strobes++;
    if (state === bus_cycle_pkg::TRANSITION) trans++;
    if (state === bus_cycle_pkg::PIPELINE_ADDRESS) pipes++;
    if (prev_trans) after_trans = state;
    if (prev_pipe) after_pipe = state;
    if (prev_pd && state !== bus_cycle_pkg::PIPELINE_DATA) after_pd = state;
    prev_trans = (state === bus_cycle_pkg::TRANSITION);
    prev_pipe = (state === bus_cycle_pkg::PIPELINE_ADDRESS);
    prev_pd = (state === bus_cycle_pkg::PIPELINE_DATA);
    if (state === bus_cycle_pkg::ADDRESS) gap = since;
    since = (done === 1'b1) ? 0 : since + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic setup(input logic [3:0] w, input logic na);
    @(negedge i_clock);
    {beats, dones, strobes, trans, pipes, drv, since} = '0;
    gap = 99;
    {prev_trans, prev_pipe, prev_pd} = 3'h0;
    after_trans = bus_cycle_pkg::IDLE;
    after_pd = bus_cycle_pkg::IDLE;
    after_pipe = bus_cycle_pkg::IDLE;
    @(posedge i_clock);
    wt <= w;
    na_en <= na;
  endtask

  // Request is held from just after an edge until the edge that takes it
  task automatic issue(input logic w, input logic b);
    int n;
    @(posedge i_clock);
    req <= 1'b1;
    wr <= w;
    bu <= b;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (accept !== 1'b1 && n < 50);
    chk(accept, 1'b1, "request never accepted");
    @(posedge i_clock);
    req <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while ((state !== bus_cycle_pkg::IDLE || ready_n !== 1'b1) && n < 200);
    chk(n < 200, 1'b1, "bus never went idle");
    repeat (2) @(negedge i_clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (2) @(negedge i_clock);
    chk(state, bus_cycle_pkg::IDLE, "state in reset");
    chk({strobe_n, bus_en}, 2'h2, "bus driven in reset");
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    flush_n <= 1'b1;
    strap <= 3'h2;
    repeat (2) @(negedge i_clock);
    chk(freq, 3'h5, "frequency select");
    chk({flush_rst, flush_req}, 2'h2, "flush at reset");
    @(posedge i_clock);
    flush_n <= 1'b0;
    @(posedge i_clock);
    flush_n <= 1'b1;
    @(negedge i_clock);
    chk(flush_req, 1'b1, "flush on clock edge");
    $display("TEST reset done");
  endtask

  task automatic t_scan;
    @(posedge i_clock);
    scan <= 1'b1;
    req <= 1'b1;
    repeat (3) @(negedge i_clock);
    chk({accept, state}, {1'b0, bus_cycle_pkg::IDLE}, "scan accepted");
    @(posedge i_clock);
    req <= 1'b0;
    scan <= 1'b0;
    $display("TEST scan done");
  endtask

  task automatic t_basic;
    setup(4'h0, 1'b0);
    issue(1'b0, 1'b0);
    issue(1'b1, 1'b1);
    wait_idle;
    chk(strobes, 2, "strobe clocks");
    chk(dones, 2, "cycles done");
    chk(beats, 5, "beats");
    chk(drv, 4, "write beats driven");
    chk(gap, 1, "idle gap");
    chk(pipes, 0, "unexpected pipelining");
    $display("TEST basic done");
  endtask

  // Extra wait states keep ready away from the turnaround clock
  task automatic t_pipe_turn;
    setup(4'h2, 1'b1);
    issue(1'b1, 1'b1);
    issue(1'b0, 1'b1);
    wait_idle;
    chk(pipes, 1, "pipe address clocks");
    chk(trans, 1, "turn clocks");
    chk(after_pipe, bus_cycle_pkg::PIPELINE_DATA, "after pipe address");
    chk(after_pd, bus_cycle_pkg::TRANSITION, "after pipe data");
    chk(after_trans, bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED, "after turn");
    chk(dones, 2, "pipelined cycles done");
    chk(beats, 8, "pipelined beats");
    chk(drv, 4, "pipelined write beats");
    $display("TEST pipeline turnaround done");
  endtask

  task automatic t_pipe_same;
    setup(4'h2, 1'b1);
    issue(1'b0, 1'b0);
    issue(1'b0, 1'b0);
    wait_idle;
    chk(pipes, 1, "pipe address clocks");
    chk(trans, 0, "no turn");
    chk(after_pipe, bus_cycle_pkg::DATA, "after pipe address");
    chk(dones, 2, "cycles done");
    // A burst keeps the older cycle open into pipeline data
    setup(4'h2, 1'b1);
    issue(1'b0, 1'b1);
    issue(1'b0, 1'b0);
    wait_idle;
    chk(after_pipe, bus_cycle_pkg::PIPELINE_DATA, "burst after pipe address");
    chk(after_pd, bus_cycle_pkg::DATA_NEXT_ADDRESS_REQUESTED, "pipe data exit");
    chk(trans, 0, "no turn after burst");
    chk(dones, 2, "burst pair done");
    $display("TEST pipeline same direction done");
  endtask

  // Last ready and a pending cycle on the same edge restart with a plain strobe
  task automatic t_pipe_late;
    setup(4'h1, 1'b1);
    issue(1'b0, 1'b0);
    issue(1'b1, 1'b0);
    wait_idle;
    chk(pipes, 0, "late pending pipelined");
    chk(strobes, 2, "late pending strobes");
    chk(dones, 2, "late pending done");
    chk(gap, 0, "address straight after ready");
    $display("TEST late pending done");
  endtask

  task automatic t_backoff;
    setup(4'h3, 1'b0);
    issue(1'b0, 1'b1);
    @(posedge i_clock);
    backoff_n_n <= 1'b0;
    @(posedge i_clock);
    backoff_n_n <= 1'b1;
    @(negedge i_clock);
    chk({state, strobe_n, bus_en}, {bus_cycle_pkg::IDLE, 2'h2}, "backoff");
    wait_idle;
    chk(dones, 0, "done after backoff");
    $display("TEST backoff done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Counts: %0d checks, %0d mismatches", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    t_reset;
    t_scan;
    t_basic;
    t_pipe_turn;
    t_pipe_same;
    t_pipe_late;
    t_backoff;
    final_report;
  end

  initial begin
    #250000;
    err_count++;
    final_report;
  end
endmodule

`default_nettype wire
